// [testbench/ppl_master_model.sv]
// master processor on the peripheral pins
module ppl_master_model (
	input wire logic clk,
	input wire ppl_pkg::ppl_byte_type portAOut,
	input wire ppl_pkg::ppl_byte_type portAOe,
	output ppl_pkg::ppl_byte_type portAIn,
	output logic strobeN,
	output logic rdSel
);
	timeunit 1ns;
	timeprecision 1ps;
	import ppl_pkg::*;
	ppl_byte_type drv = 8'h5A; // master value, inverted once released
	// wire level: device where enabled, else master value
	assign portAIn = (portAOe & portAOut) | (~portAOe & drv);
	initial begin
		strobeN = 1'b1;
		rdSel = 1'b1;
	end
	// one read strobe, pins sampled while low
	task automatic readByte(output ppl_byte_type q);
		rdSel <= 1'b1;
		@(posedge clk);
		strobeN <= 1'b0;
		repeat (3) @(posedge clk);
		q = portAIn;
		strobeN <= 1'b1;
		@(posedge clk);
	endtask
	// optional busy poll, then one write strobe
	task automatic writeByte(input ppl_byte_type d, input bit poll);
		ppl_byte_type q;
		for (int i = 0; i < 20 && poll; i++) begin
			readByte(q);
			if (q[7])
				break;
		end
		rdSel <= 1'b0;
		drv <= d;
		@(posedge clk);
		strobeN <= 1'b0;
		repeat (2) @(posedge clk);
		strobeN <= 1'b1;
		drv <= ~d;
		@(posedge clk);
	endtask
endmodule

// [testbench/ppl_port_modes_props.sv]
// pin checker for the port-mode block
`include "ppl_regs.svh"
module ppl_port_modes_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire ppl_pkg::ppl_byte_type portAOut,
	input wire ppl_pkg::ppl_byte_type portAOe,
	input wire logic port_b_bit_zero,
	input wire logic port_b_bit_one,
	input wire logic portB0Out,
	input wire logic portB0Oe,
	input wire logic portB1Oe,
	input wire logic romFetch
);
	timeunit 1ns;
	timeprecision 1ps;
	import ppl_pkg::*;
	ppl_byte_type sw [0:4]; // copy of mode, dir and out registers
	logic wip; // write under way, registers may lag the copy
	logic pm; // peripheral mode alone
	logic rm; // rom mode alone
	assign pm = sw[0][`PPL_MODE_PERIPH_BIT] & ~sw[0][`PPL_MODE_EXTERNAL_ROM_MODE_SELECT_BIT];
	assign rm = sw[0][`PPL_MODE_EXTERNAL_ROM_MODE_SELECT_BIT] & ~sw[0][`PPL_MODE_PERIPH_BIT];
	// follow every accepted write to the five copied registers, offsets below 0x14
	always_ff @(posedge clk) begin
		if (reset) begin
			sw <= '{default: 8'h00};
			wip <= 1'b0;
		end else begin
			if (awvalid)
				wip <= 1'b1;
			if (bvalid && bready)
				wip <= 1'b0;
			if (wvalid && wready && awaddr < 8'h14)
				sw[awaddr[4:2]] <= wdata[7:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rd;
		pm && !wip && !port_b_bit_zero && port_b_bit_one |=>
			portAOe[6:0] == 7'h7F && portAOut[6:0] == sw[3][6:0];
	endproperty
	a_rd: assert property (p_rd) else $error("read not driven");
	property p_flt;
		pm && !wip && (port_b_bit_zero || !port_b_bit_one) |=> portAOe[6:0] == 7'h00;
	endproperty
	a_flt: assert property (p_flt) else $error("port a driven off read");
	property p_pins;
		pm && !wip |-> !portB0Oe && !portB1Oe;
	endproperty
	a_pins: assert property (p_pins) else $error("port b driven");
	property p_gen;
		!pm && !wip |-> portAOe == sw[1] && portB0Oe == sw[2][0] && portB1Oe == sw[2][1];
	endproperty
	a_gen: assert property (p_gen) else $error("enables not general");
	property p_clk;
		rm && $past(rm, 3) && !wip && $past(wip, 3) == 1'b0 && sw[3][7] |->
			portAOut[7] != $past(portAOut[7], 2);
	endproperty
	a_clk: assert property (p_clk) else $error("rom clock not quarter rate");
	property p_and;
		rm && !wip && !sw[3][7] |=> !portAOut[7];
	endproperty
	a_and: assert property (p_and) else $error("rom clock not gated");
	property p_fell;
		rm && !wip && sw[4][0] && $fell(portB0Out) |-> !portB0Out [*4] ##1 portB0Out;
	endproperty
	a_fell: assert property (p_fell) else $error("strobe length wrong");
	property p_go;
		rm && !wip && sw[4][0] && romFetch && portB0Out |-> ##[1:3] !portB0Out;
	endproperty
	a_go: assert property (p_go) else $error("fetch gave no strobe");
endmodule
bind ppl_port_modes ppl_port_modes_props ppl_port_modes_props_inst (
	.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.portAOut(portAOut), .portAOe(portAOe), .port_b_bit_zero(port_b_bit_zero),
	.port_b_bit_one(port_b_bit_one), .portB0Out(portB0Out), .portB0Oe(portB0Oe),
	.portB1Oe(portB1Oe), .romFetch(romFetch)
);

// [testbench/ppl_port_modes_tb.sv]
// self-checking bench of the port-mode block
`include "ppl_regs.svh"
module ppl_port_modes_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ppl_pkg::*;
	typedef struct {logic [7:0] a; logic wr; logic [7:0] d; logic [33:0] e;} ppl_row_type;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, romFetch = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, b0, b1, b0Out, b0Oe, b1Out, b1Oe;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	ppl_byte_type aIn, aOut, aOe, q;
	int errors = 0;
	int compares = 0;
	int n;
	int nibbles = 0; // address nibbles the far rom would latch
	logic b0Last = 1'b1; // strobe pin one clock back
	// far-side rom: a strobe fall with direction low latches a nibble
	always @(posedge clk) begin
		b0Last <= b0Out;
		if (b0Last && !b0Out && !b1Out && b0Oe) begin
			nibbles++;
		end
	end
	// {offset, write, byte, {resp, data} expected}
	ppl_row_type rows [13] = '{
		'{`PPL_MODE_OFS, 1'b0, 8'h00, 34'h0},
		'{8'h24, 1'b0, 8'h00, 34'h200000000},
		'{8'h24, 1'b1, 8'h55, 34'h200000000},
		'{`PPL_MODE_OFS, 1'b1, 8'h50, 34'h0},
		'{`PPL_STATUS_OFS, 1'b0, 8'h00, 34'h11},
		'{`PPL_MODE_OFS, 1'b1, 8'h40, 34'h0},
		'{`PPL_OUT_A_OFS, 1'b1, 8'hA5, 34'h0},
		'{`PPL_MODE_OFS, 1'b0, 8'h00, 34'h40},
		'{`PPL_DIR_A_OFS, 1'b1, 8'h80, 34'h0},
		'{`PPL_DIR_B_OFS, 1'b1, 8'h03, 34'h0},
		'{`PPL_OUT_A_OFS, 1'b1, 8'h80, 34'h0},
		'{`PPL_OUT_B_OFS, 1'b1, 8'h01, 34'h0},
		'{`PPL_MODE_OFS, 1'b1, 8'h10, 34'h0}
	};
	ppl_port_modes ppl_port_modes_inst (.clk(clk), .reset(reset), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(1'b1), .portAIn(aIn), .portAOut(aOut), .portAOe(aOe), .port_b_bit_zero(b0),
		.port_b_bit_one(b1), .portB0Out(b0Out), .portB0Oe(b0Oe), .portB1Out(b1Out),
		.portB1Oe(b1Oe), .romFetch(romFetch));
	ppl_master_model ppl_master_model_inst (.clk(clk), .portAOut(aOut), .portAOe(aOe),
		.portAIn(aIn), .strobeN(b0), .rdSel(b1));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one write, both channels offered together
	task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
	endtask
	// one read, answer compared
	task automatic rdc(input logic [7:0] a, input logic [33:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		check({rresp, rdata}, e);
	endtask
	task automatic runRows(input int lo, input int hi);
		logic [1:0] r;
		for (int i = lo; i < hi; i++) begin
			if (rows[i].wr) begin
				axw(rows[i].a, rows[i].d, r);
				check({r, 32'h0}, rows[i].e);
			end else
				rdc(rows[i].a, rows[i].e);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
	initial begin
		logic [1:0] r;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		runRows(0, 8);
		rdc(`PPL_PINS_OFS, 34'h35A);
		ppl_master_model_inst.readByte(q);
		check(34'(q), 34'hA5);
		ppl_master_model_inst.writeByte(8'hC3, 1'b1);
		rdc(`PPL_IN_A_OFS, 34'hC3);
		rdc(`PPL_OUT_A_OFS, 34'h25);
		ppl_master_model_inst.readByte(q);
		check(34'(q), 34'h25);
		rdc(`PPL_FIFO_OFS, 34'h1C3);
		for (int i = 0; i < 17; i++)
			ppl_master_model_inst.writeByte(8'(i), 1'b0);
		rdc(`PPL_STATUS_OFS, 34'h1E);
		for (int i = 0; i < 16; i++)
			rdc(`PPL_FIFO_OFS, 34'(i + 256));
		rdc(`PPL_STATUS_OFS, 34'h18);
		axw(`PPL_STATUS_OFS, 8'h08, r);
		rdc(`PPL_STATUS_OFS, 34'h10);
		runRows(8, 13);
		for (int k = 0; k < 4; k++) begin
			if (k == 2)
				axw(`PPL_OUT_A_OFS, 8'h00, r);
			if (k == 3)
				axw(`PPL_OUT_B_OFS, 8'h02, r);
			repeat (4) @(posedge clk);
			romFetch <= (k == 1);
			n = 0;
			repeat (8) begin
				@(posedge clk);
				romFetch <= 1'b0;
				n += (k[0] ? !b0Out : aOut[7]);
			end
			check(34'(n), 34'(k == 0 ? 4 : k == 1 ? 4 : k == 2 ? 0 : 8));
		end
		check(34'(nibbles), 34'h1);
		check(34'(b1Out), 34'h1);
		// mid-run reset: pins released, mode cleared
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check(34'({aOe, b0Oe, b1Oe, b0Out, b1Out, aOut}), 34'h0);
		rdc(`PPL_MODE_OFS, 34'h0);
		stop_test();
	end
endmodule

// [verilog/ppl_fifo.sv]
// no logic of its own: the receive fifo sits beside the port-mode logic

// [verilog/ppl_pkg.sv]
// types shared by the port-mode block
package ppl_pkg;
	// ----------------------------------------
	// port function selected by the mode bits
	// ----------------------------------------
	typedef enum logic [1:0] {
		PPL_GENERAL = 2'b00,
		PPL_PERIPH = 2'b01,
		PPL_EXTERNAL_ROM_MODE_SELECT = 2'b10
	} ppl_mode_type;
	typedef logic [7:0] ppl_byte_type;
endpackage

// [verilog/ppl_port_modes.sv]
// port-mode logic: peripheral host port and external speech rom link
// Overview of operation
// R1: mode bit six selects peripheral mode
// R2: port b bit zero is low chip enable
// R3: port b bit one picks transfer direction
// R4: master write strobe clears set busy latch
// R5: reads carry seven bits, writes eight
// R6: master floats port a during reads
// R7: peripheral mode needs ports as inputs
// R8: both modes together is refused
// R9: master polls busy before writing
// R10: write strobe latches port a pins
// R11: firmware polls busy then strobe high
// R12: response is data plus busy bit set
// R13: cleared busy latch marks new command
// R14: mode bit four selects external rom mode
// R15: strobe pin is latch and fetch strobe
// R16: rom clock is latch and quarter clock
// R17: rom takes nibbles on strobe fall
// R18: drive port a only on master read; busy bit 7 is also driven whenever dirA_reg[7] is set
// R19: free running divide by four counter
`include "ppl_regs.svh"
module ppl_port_modes (
	input wire logic clk,
	input wire logic reset,
	// axi4-lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// port a pins
	input wire ppl_pkg::ppl_byte_type portAIn,
	output ppl_pkg::ppl_byte_type portAOut,
	output ppl_pkg::ppl_byte_type portAOe,
	// port b low pins
	input wire logic port_b_bit_zero,
	input wire logic port_b_bit_one,
	output logic portB0Out,
	output logic portB0Oe,
	output logic portB1Out,
	output logic portB1Oe,
	// rom fetch request, one pulse per nibble
	input wire logic romFetch
);
	import ppl_pkg::*;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	ppl_byte_type mode_reg; // mode bits
	ppl_byte_type dirA_reg; // port a direction, 1 output
	logic [1:0] dirB_reg; // port b low direction
	ppl_byte_type outA_reg; // port a output latch
	logic [1:0] outB_reg; // port b low output latch
	ppl_byte_type inA_reg; // port a input latch
	logic overrun_reg; // fifo dropped a written byte
	logic strobeLow_reg; // delayed strobe for edges
	logic [1:0] div_reg; // quarter-rate divider
	logic [2:0] fetchCnt_reg; // hardware strobe length
	ppl_mode_type activeMode;
	logic strobeFall;
	logic hostWrite;
	logic hostRead;
	logic conflict;
	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	// conflicting setting leaves the ports general
	always_comb begin
		conflict = mode_reg[`PPL_MODE_PERIPH_BIT] && mode_reg[`PPL_MODE_EXTERNAL_ROM_MODE_SELECT_BIT]; // R8
		if (conflict) begin
			activeMode = PPL_GENERAL; // R8
		end else if (mode_reg[`PPL_MODE_PERIPH_BIT]) begin
			activeMode = PPL_PERIPH; // R1
		end else if (mode_reg[`PPL_MODE_EXTERNAL_ROM_MODE_SELECT_BIT]) begin
			activeMode = PPL_EXTERNAL_ROM_MODE_SELECT; // R14
		end else begin
			activeMode = PPL_GENERAL;
		end
	end
	// strobe fall and direction qualify a write, strobe low and direction a read
	assign strobeFall = !port_b_bit_zero && !strobeLow_reg; // R2
	assign hostWrite = (activeMode == PPL_PERIPH) && strobeFall && !port_b_bit_one; // R3
	assign hostRead = (activeMode == PPL_PERIPH) && !port_b_bit_zero && port_b_bit_one; // R3
	// ----------------------------------------
	// received-byte fifo
	// ----------------------------------------
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	ppl_byte_type fifoOutData;
	ppl_fifo #(
		.WIDTH(8),
		.DEPTH(`PPL_FIFO_DEPTH)
	) rxFifo (
		.clk(clk),
		.reset(reset),
		.inValid(hostWrite),
		.inReady(fifoInReady),
		.inData(portAIn),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);
	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	// mapped-offset check shared by both channels
	function automatic logic decodeOk(input logic [7:0] addr);
		decodeOk = (addr[1:0] == 2'b00) && (addr <= `PPL_FIFO_OFS);
	endfunction
	logic awHeld_reg;
	logic wHeld_reg;
	logic [7:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic doWrite;
	assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
	// address and data taken in either order
	always_ff @(posedge clk) begin
		if (reset) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else begin
			awready <= !awHeld_reg && !awready && awvalid;
			wready <= !wHeld_reg && !wready && wvalid;
			if (awvalid && awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
			end
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				bvalid <= 1'b1;
				bresp <= decodeOk(awAddr_reg) ? 2'b00 : 2'b10;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	logic wrMode;
	logic wrOutA;
	assign wrMode = doWrite && wStrb_reg[0] && (awAddr_reg == `PPL_MODE_OFS);
	assign wrOutA = doWrite && wStrb_reg[0] && (awAddr_reg == `PPL_OUT_A_OFS);
	// ----------------------------------------
	// software registers
	// ----------------------------------------
	// mode, directions and port b latch
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_reg <= `PPL_MODE_RESET;
			dirA_reg <= `PPL_DIR_RESET;
			dirB_reg <= 2'b00;
			outB_reg <= 2'b00;
		end else if (doWrite && wStrb_reg[0]) begin
			if (wrMode) begin
				mode_reg <= wData_reg[7:0]; // R1 R14
			end
			if (awAddr_reg == `PPL_DIR_A_OFS) begin
				dirA_reg <= wData_reg[7:0];
			end
			if (awAddr_reg == `PPL_DIR_B_OFS) begin
				dirB_reg <= wData_reg[1:0];
			end
			if (awAddr_reg == `PPL_OUT_B_OFS) begin
				outB_reg <= wData_reg[1:0];
			end
		end
	end
	// port a output latch; strobe clear wins over software
	always_ff @(posedge clk) begin
		if (reset) begin
			outA_reg <= `PPL_OUT_RESET;
		end else begin
			if (wrOutA) begin
				outA_reg <= wData_reg[7:0]; // R12
			end
			if (hostWrite && outA_reg[`PPL_BUSY_BIT]) begin
				outA_reg[`PPL_BUSY_BIT] <= 1'b0; // R4 R13
			end
		end
	end
	// input latch catches all eight pins on a master write
	always_ff @(posedge clk) begin
		if (reset) begin
			inA_reg <= 8'h00;
			overrun_reg <= 1'b0;
			strobeLow_reg <= 1'b0;
		end else begin
			strobeLow_reg <= !port_b_bit_zero;
			if (hostWrite) begin
				inA_reg <= portAIn; // R10 R5
			end
			if (hostWrite && !fifoInReady) begin
				overrun_reg <= 1'b1;
			end else if (doWrite && (awAddr_reg == `PPL_STATUS_OFS) && wData_reg[3]) begin
				overrun_reg <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	ppl_byte_type statusByte;
	assign statusByte = {3'b000, port_b_bit_zero, overrun_reg, !fifoInReady,
		fifoOutValid, conflict}; // R11 R8
	assign fifoPop = arvalid && arready && (araddr == `PPL_FIFO_OFS);
	// register read mux, unmapped answers slverr
	always_ff @(posedge clk) begin
		if (reset) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'b00;
		end else begin
			arready <= !arready && !rvalid && arvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= decodeOk(araddr) ? 2'b00 : 2'b10;
				unique case (araddr)
					`PPL_MODE_OFS: rdata <= {24'h000000, mode_reg};
					`PPL_DIR_A_OFS: rdata <= {24'h000000, dirA_reg};
					`PPL_DIR_B_OFS: rdata <= {30'h00000000, dirB_reg};
					`PPL_OUT_A_OFS: rdata <= {24'h000000, outA_reg}; // R11
					`PPL_OUT_B_OFS: rdata <= {30'h00000000, outB_reg};
					`PPL_IN_A_OFS: rdata <= {24'h000000, inA_reg};
					`PPL_PINS_OFS: rdata <= {22'h000000, port_b_bit_one, port_b_bit_zero,
						portAIn};
					`PPL_STATUS_OFS: rdata <= {24'h000000, statusByte};
					`PPL_FIFO_OFS: rdata <= {23'h000000, fifoOutValid, fifoOutData};
					default: rdata <= 32'h0000_0000;
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// external rom clock and strobe
	// ----------------------------------------
	// free-running quarter-rate divider
	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg <= 2'b00;
		end else begin
			div_reg <= div_reg + 2'b01; // R19
		end
	end
	// hardware strobe held low for a fetch
	always_ff @(posedge clk) begin
		if (reset) begin
			fetchCnt_reg <= 3'b000;
		end else if (romFetch && (activeMode == PPL_EXTERNAL_ROM_MODE_SELECT) && (fetchCnt_reg == 3'b000)) begin
			fetchCnt_reg <= 3'(`PPL_STROBE_CYCLES); // R15
		end else if (fetchCnt_reg != 3'b000) begin
			fetchCnt_reg <= fetchCnt_reg - 3'b001;
		end
	end
	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// each mode arranges the pins its own way
	always_ff @(posedge clk) begin
		if (reset) begin
			portAOut <= 8'h00;
			portAOe <= 8'h00;
			portB0Out <= 1'b0;
			portB0Oe <= 1'b0;
			portB1Out <= 1'b0;
			portB1Oe <= 1'b0;
		end else begin
			portB1Out <= outB_reg[1];
			portB1Oe <= dirB_reg[1];
			unique case (activeMode)
				PPL_PERIPH: begin
					portAOut <= outA_reg;
					// busy line driven always if output, else on reads
					portAOe <= {dirA_reg[7] | hostRead, {7{hostRead}}}; // R18 R7 R5
					portB0Out <= 1'b0;
					portB0Oe <= 1'b0; // R7
					portB1Oe <= 1'b0; // R7
				end
				PPL_EXTERNAL_ROM_MODE_SELECT: begin
					portAOut <= {outA_reg[7] & !div_reg[1], outA_reg[6:0]}; // R16
					portAOe <= dirA_reg;
					portB0Out <= outB_reg[0] & (fetchCnt_reg == 3'b000); // R15
					portB0Oe <= dirB_reg[0];
				end
				PPL_GENERAL: begin
					portAOut <= outA_reg;
					portAOe <= dirA_reg;
					portB0Out <= outB_reg[0];
					portB0Oe <= dirB_reg[0];
				end
				default: begin
					portAOut <= outA_reg;
					portAOe <= 8'h00;
					portB0Out <= 1'b0;
					portB0Oe <= 1'b0;
				end
			endcase
		end
	end
endmodule
// ----------------------------------------
// parameterised valid/ready fifo held in flip-flops
// ----------------------------------------
module ppl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage words
	logic [AW-1:0] wrPtr_reg; // tail index
	logic [AW-1:0] rdPtr_reg; // head index
	logic [AW:0] count_reg; // occupancy, one bit wider than an index
	logic push; // word accepted this cycle
	logic pop; // word handed out this cycle
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign inReady = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem[rdPtr_reg];
	// storage written at the tail
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end
	// pointers and occupancy
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= AW'((wrPtr_reg + 1'b1) % DEPTH);
			end
			if (pop) begin
				rdPtr_reg <= AW'((rdPtr_reg + 1'b1) % DEPTH);
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [verilog/ppl_regs.svh]
// register offsets, field positions, reset values and timing counts for the port-mode block
`ifndef PPL_REGS_SVH
`define PPL_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPL_MODE_OFS 8'h00
`define PPL_DIR_A_OFS 8'h04
`define PPL_DIR_B_OFS 8'h08
`define PPL_OUT_A_OFS 8'h0C
`define PPL_OUT_B_OFS 8'h10
`define PPL_IN_A_OFS 8'h14
`define PPL_PINS_OFS 8'h18
`define PPL_STATUS_OFS 8'h1C
`define PPL_FIFO_OFS 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define PPL_MODE_PERIPH_BIT 6
`define PPL_MODE_EXTERNAL_ROM_MODE_SELECT_BIT 4
`define PPL_BUSY_BIT 7
`define PPL_ST_CONFLICT_BIT 0
`define PPL_ST_FIFO_VALID_BIT 1
`define PPL_ST_FIFO_FULL_BIT 2
`define PPL_ST_OVERRUN_BIT 3
`define PPL_ST_STROBE_BIT 4
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define PPL_MODE_RESET 8'h00
`define PPL_DIR_RESET 8'h00
`define PPL_OUT_RESET 8'h00
`define PPL_CLK_DIV 4
`define PPL_STROBE_CYCLES 4
`define PPL_FIFO_DEPTH 16
`endif
